//--- verilog/spmc_seq.sv
// Sleep and Idle power-mode sequencer with watchdog NMI reset path.
// Assumes CPU, interrupt controller and reset sources run on mclk;
// only the brown-out comparator pin is asynchronous.
//
// Contract
// - Sleep halts CPU, gates most peripheral clocks
// - Clock failure monitor off during Sleep
// - Brown-out detection stays on in Sleep
// - Entering Sleep never clears the watchdog
// - Sleep-capable peripherals keep running in Sleep
// - I/O pins keep driving during Sleep
// - Higher-priority sleep-capable interrupt wakes from Sleep
// - Low-priority interrupt moves Sleep to Idle
// - Sleep exit waits on oscillator start-up; the Sleep-to-Idle exit skips the wait
// - Idle halts CPU and gates its clock, bus clocks stay on
// - Halt-in-idle peripherals stop in Idle
// - Halt with select clear enters Idle
// - Higher-priority enabled interrupt ends Idle
// - Any reset or watchdog time-out ends Idle
// - Regulator keep bit picks Sleep regulator state
// - Watchdog expiry raises NMI and sets flag
// - NMI countdown expiry resets the device
`default_nettype none

module spmc_seq
    import spmc_pkg::*;
#(
    parameter int NPERIPH = 8,  // Peripherals with halt-in-idle control
    parameter int PRIO_W  = 3   // Interrupt priority width
) (
    input  wire logic               mclk,                   // Core clock
    input  wire logic               srst,                   // Sync reset, high
    input  wire logic               halt_exec,              // Halt instr pulse
    input  wire logic [31:0]        oscillator_control_reg, // Osc control word
    input  wire logic [31:0]        power_control_reg,      // Power control word
    input  wire logic               osc_needs_startup,      // Slow osc chosen
    input  wire logic               irq_req,                // Interrupt pending
    input  wire logic               irq_enabled,            // Source enabled
    input  wire logic               irq_in_sleep,           // Source runs in Sleep
    input  wire logic [PRIO_W-1:0]  irq_priority,           // Pending priority
    input  wire logic [PRIO_W-1:0]  cpu_priority,           // Current CPU priority
    input  wire logic               device_reset_req,       // Any reset source
    input  wire logic               wdt_timeout,            // Watchdog time-out
    input  wire logic               brownout_pin,           // Async BOR comparator
    input  wire logic [NPERIPH-1:0] halt_in_idle_sel,       // Per-periph stop
    input  wire logic               nmi_flag_clr,           // Clear watchdog flag
    input  wire logic [7:0]         nmi_cnt_load,           // Countdown start
    output logic                    cpu_halt,               // CPU held
    output logic                    cpu_clk_en,             // CPU clock gate
    output logic                    pb_clk_en,              // Periph bus clocks
    output logic [NPERIPH-1:0]      periph_run,             // Per-periph enable
    output logic                    sleep_periph_en,        // Sleep-capable set
    output logic                    watchdog_run,           // Watchdog counts
    output logic                    clock_fail_monitor_en,  // Monitor active
    output logic                    brownout_reset_detect_en, // BOR armed
    output logic                    io_drive_keep,          // Pins keep driving
    output logic                    regulator_standby,      // Regulator standby
    output logic [3:0]              power_mode,             // Current state
    output logic                    nmi_out,                // NMI pulse
    output logic                    device_reset_out,       // Reset pulse
    output logic [31:0]             nmi_control_reg         // NMI status word
);

    // ========================================================
    // Field extraction from the control words
    logic sleep_select;
    logic regulator_sleep_keep;
    assign sleep_select         = oscillator_control_reg[OSC_SLEEP_SEL_BIT];
    assign regulator_sleep_keep = power_control_reg[PWR_REG_KEEP_BIT];

    // ========================================================
    // Brown-out pin synchroniser, two flops
    logic bor_meta;
    logic bor_sync;
    logic bor_seen;
    logic next_bor_seen;

    // Second flop alone feeds logic; edge caught from it
    always_comb begin
        next_bor_seen = bor_sync;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bor_meta <= 1'b0;
            bor_sync <= 1'b0;
            bor_seen <= 1'b0;
        end else begin
            bor_meta <= brownout_pin;
            bor_sync <= bor_meta;
            bor_seen <= next_bor_seen;
        end
    end

    logic bor_event;
    // Detection never gated by mode, so Sleep cannot mask it
    assign bor_event = bor_sync && !bor_seen;

    // ========================================================
    // Countdown step divider, one-cycle enable
    localparam logic [7:0] TICK_LAST = 8'(NMI_TICK_CYC - 1);
    logic [7:0] tick_cnt;
    logic [7:0] next_tick_cnt;
    logic       nmi_tick;

    always_comb begin
        if (tick_cnt == TICK_LAST) begin
            next_tick_cnt = 8'h00;
        end else begin
            next_tick_cnt = tick_cnt + 8'h01;
        end
    end

    assign nmi_tick = (tick_cnt == TICK_LAST);

    always_ff @(posedge mclk) begin
        if (srst) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ========================================================
    // Watchdog NMI flag and reset countdown
    logic       nmi_flag;
    logic [7:0] nmi_count;
    logic       nmi_pulse;
    logic       nmi_rst_pulse;

    // Expiry goes to NMI first, never straight to reset
    spmc_nmi_cnt u_nmi (
        .mclk        (mclk),
        .srst        (srst),
        .wdt_expire  (wdt_timeout),
        .flag_clr    (nmi_flag_clr),
        .cnt_load    (nmi_cnt_load),
        .tick        (nmi_tick),
        .nmi_flag    (nmi_flag),
        .count       (nmi_count),
        .nmi_pulse   (nmi_pulse),
        .reset_pulse (nmi_rst_pulse)
    );

    // ========================================================
    // Wake conditions
    logic prio_hi;
    logic irq_wake;
    logic sleep_irq;
    logic any_reset;
    assign prio_hi   = irq_priority > cpu_priority;
    assign irq_wake  = irq_req && irq_enabled && prio_hi;
    assign sleep_irq = irq_req && irq_enabled && irq_in_sleep;
    assign any_reset = device_reset_req || bor_event || nmi_rst_pulse;

    // ========================================================
    // Mode state machine and wake-delay counter
    localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD = WAKE_CNT_W'(WAKE_DLY_CYC);
    localparam logic [WAKE_CNT_W-1:0] WAKE_MIN  = WAKE_CNT_W'(1);
    spmc_state_e             state;
    spmc_state_e             next_state;
    logic [WAKE_CNT_W-1:0]   wake_cnt;
    logic [WAKE_CNT_W-1:0]   next_wake_cnt;
    logic [WAKE_CNT_W-1:0]   wake_len;

    // Slow oscillators need their start-up time before the CPU runs
    assign wake_len = osc_needs_startup ? WAKE_LOAD : WAKE_MIN;

    always_comb begin
        next_state    = state;
        next_wake_cnt = wake_cnt;
        case (state)
            SPMC_RUN: begin
                if (halt_exec && sleep_select) begin
                    next_state = SPMC_SLEEP;
                end else if (halt_exec) begin
                    next_state = SPMC_IDLE;
                end
            end
            SPMC_IDLE: begin
                if (any_reset || wdt_timeout) begin
                    next_state = SPMC_RUN;
                end else if (irq_wake) begin
                    next_state = SPMC_RUN;
                end
            end
            SPMC_SLEEP: begin
                if (any_reset || wdt_timeout) begin
                    next_state    = SPMC_WAKE;
                    next_wake_cnt = wake_len;
                end else if (sleep_irq && prio_hi) begin
                    next_state    = SPMC_WAKE;
                    next_wake_cnt = wake_len;
                end else if (sleep_irq) begin
                    // CPU stays halted, bus clocks return
                    next_state = SPMC_IDLE;
                end
            end
            SPMC_WAKE: begin
                if (wake_cnt <= WAKE_MIN) begin
                    next_state    = SPMC_RUN;
                    next_wake_cnt = '0;
                end else begin
                    next_wake_cnt = wake_cnt - WAKE_MIN;
                end
            end
            default: begin
                next_state    = SPMC_RUN;
                next_wake_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state    <= SPMC_RUN;
            wake_cnt <= '0;
        end else begin
            state    <= next_state;
            wake_cnt <= next_wake_cnt;
        end
    end

    // ========================================================
    // Output decode from the next state, registered below
    logic n_run;
    logic n_idle;
    logic n_sleep;
    logic n_wake;
    assign n_run   = (next_state == SPMC_RUN);
    assign n_idle  = (next_state == SPMC_IDLE);
    assign n_sleep = (next_state == SPMC_SLEEP);
    assign n_wake  = (next_state == SPMC_WAKE);

    logic               next_cpu_halt;
    logic               next_cpu_clk_en;
    logic               next_pb_clk_en;
    logic               next_cfm_en;
    logic               next_reg_stby;
    logic [NPERIPH-1:0] next_periph_run;
    logic               next_dev_rst;
    logic [31:0]        next_nmi_reg;

    always_comb begin
        next_cpu_halt   = !n_run;
        next_cpu_clk_en = n_run;
        // Idle keeps the bus clocks, CPU clock runs in Run only; Sleep and its exit delay gate them
        next_pb_clk_en  = n_run || n_idle;
        next_cfm_en     = !(n_sleep || n_wake);
        next_reg_stby   = n_sleep && !regulator_sleep_keep;
        next_dev_rst    = any_reset;
        next_nmi_reg    = 32'h0000_0000;
        next_nmi_reg[NMI_WDT_FLAG_BIT]         = nmi_flag;
        next_nmi_reg[NMI_CNT_MSB:NMI_CNT_LSB]  = nmi_count;
    end

    // Per-peripheral enables
    genvar gi;
    generate
        for (gi = 0; gi < NPERIPH; gi++) begin : g_periph
            assign next_periph_run[gi] =
                n_run || (n_idle && !halt_in_idle_sel[gi]);
        end
    endgenerate

    // All outputs come straight from flops
    always_ff @(posedge mclk) begin
        if (srst) begin
            cpu_halt                 <= 1'b0;
            cpu_clk_en               <= 1'b1;
            pb_clk_en                <= 1'b1;
            periph_run               <= '1;
            sleep_periph_en          <= 1'b0;
            watchdog_run             <= 1'b0;
            clock_fail_monitor_en    <= 1'b1;
            brownout_reset_detect_en <= 1'b0;
            io_drive_keep            <= 1'b0;
            regulator_standby        <= 1'b0;
            power_mode               <= SPMC_RUN;
            nmi_out                  <= 1'b0;
            device_reset_out         <= 1'b0;
            nmi_control_reg          <= 32'h0000_0000;
        end else begin
            cpu_halt                 <= next_cpu_halt;
            cpu_clk_en               <= next_cpu_clk_en;
            pb_clk_en                <= next_pb_clk_en;
            periph_run               <= next_periph_run;
            sleep_periph_en          <= 1'b1;
            watchdog_run             <= 1'b1;  // No clear on Sleep entry
            clock_fail_monitor_en    <= next_cfm_en;
            brownout_reset_detect_en <= 1'b1;
            io_drive_keep            <= 1'b1;
            regulator_standby        <= next_reg_stby;
            power_mode               <= next_state;
            nmi_out                  <= nmi_pulse;
            device_reset_out         <= next_dev_rst;
            nmi_control_reg          <= next_nmi_reg;
        end
    end

    // ========================================================
    // Checks
    localparam int WAKE_MAX = 260;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    AST_SLEEP_GATE: assert property (
        state == SPMC_SLEEP |-> cpu_halt && !pb_clk_en && !cpu_clk_en)
        else $error("sleep left clocks running");
    AST_CFM_OFF: assert property (
        state == SPMC_SLEEP |-> !clock_fail_monitor_en)
        else $error("clock monitor active in sleep");
    AST_BOR_ON: assert property (
        !$past(srst) && state == SPMC_SLEEP |-> brownout_reset_detect_en)
        else $error("brown-out detect off in sleep");
    AST_SLEEP_ENTER: assert property (
        state == SPMC_RUN && halt_exec && sleep_select |=> state == SPMC_SLEEP)
        else $error("halt with select set missed sleep");
    AST_IDLE_ENTER: assert property (
        state == SPMC_RUN && halt_exec && !sleep_select |=> state == SPMC_IDLE)
        else $error("halt with select clear missed idle");
    AST_SLEEP_TO_IDLE: assert property (
        state == SPMC_SLEEP && sleep_irq && !prio_hi && !any_reset && !wdt_timeout
        |=> state == SPMC_IDLE && pb_clk_en && cpu_halt)
        else $error("low priority wake did not go idle");
    AST_IDLE_WAKE: assert property (
        state == SPMC_IDLE && irq_wake |=> state == SPMC_RUN && !cpu_halt)
        else $error("idle not left on high priority irq");
    AST_WAKE_DELAY: assert property (
        $rose(state == SPMC_WAKE) |-> ##[1:WAKE_MAX] state == SPMC_RUN)
        else $error("wake delay overran");
    AST_REG_STBY: assert property (
        state == SPMC_SLEEP |-> regulator_standby == !$past(regulator_sleep_keep))
        else $error("regulator state wrong in sleep");
    AST_IDLE_HALT_IN_IDLE_SEL: assert property (
        state == SPMC_IDLE |-> periph_run == ~$past(halt_in_idle_sel))
        else $error("halt-in-idle select ignored");

    COV_SLEEP_IDLE: cover property (state == SPMC_SLEEP ##1 state == SPMC_IDLE);
    COV_SLEEP_WAKE: cover property (state == SPMC_WAKE ##1 state == SPMC_RUN);
    COV_IDLE_RUN:   cover property (state == SPMC_IDLE ##1 state == SPMC_RUN);

endmodule : spmc_seq

`default_nettype wire

//--- inc/spmc_pkg.sv
// Constants and types shared by the power-mode sequencer files.
// Assumes a single 250 MHz clock feeding every file that imports it.
`default_nettype none

package spmc_pkg;

    // ========================================================
    // Register field positions
    localparam int OSC_SLEEP_SEL_BIT = 4;   // Sleep select in oscillator control
    localparam int PWR_REG_KEEP_BIT  = 0;   // Regulator keep in power control
    localparam int NMI_WDT_FLAG_BIT  = 24;  // Watchdog NMI flag in NMI control
    localparam int NMI_CNT_MSB       = 7;   // Countdown field top bit
    localparam int NMI_CNT_LSB       = 0;   // Countdown field low bit
    localparam int NMI_CNT_W         = NMI_CNT_MSB - NMI_CNT_LSB + 1;

    // ========================================================
    // Reset values
    localparam logic [7:0] NMI_CNT_RST   = 8'h00;
    localparam logic [3:0] NMI_TICK_RST  = 4'h0;

    // ========================================================
    // Timing
    localparam int MCLK_MHZ      = 250;     // Core clock rate
    localparam int WAKE_DLY_NS   = 1000;    // Oscillator start-up wait on wake
    localparam int WAKE_DLY_CYC  = (WAKE_DLY_NS * MCLK_MHZ + 999) / 1000;
    localparam int NMI_TICK_NS   = 40;      // Period of one countdown step
    localparam int NMI_TICK_CYC  = (NMI_TICK_NS * MCLK_MHZ) / 1000;
    localparam int WAKE_CNT_W    = 10;

    // ========================================================
    // Power-mode states, one-hot
    typedef enum logic [3:0] {
        SPMC_RUN   = 4'b0001,
        SPMC_IDLE  = 4'b0010,
        SPMC_SLEEP = 4'b0100,
        SPMC_WAKE  = 4'b1000
    } spmc_state_e;

endpackage : spmc_pkg

`default_nettype wire

//--- verilog/spmc_nmi_cnt.sv
// Watchdog NMI flag and the countdown that ends in a device reset.
// Assumes all inputs come from logic on mclk; tick is a one-cycle enable.
`default_nettype none

module spmc_nmi_cnt
    import spmc_pkg::*;
(
    input  wire logic                 mclk,        // Core clock
    input  wire logic                 srst,        // Sync reset, high
    input  wire logic                 wdt_expire,  // Watchdog expiry pulse
    input  wire logic                 flag_clr,    // Software clears flag
    input  wire logic [NMI_CNT_W-1:0] cnt_load,    // Countdown start value
    input  wire logic                 tick,        // Countdown step enable
    output logic                      nmi_flag,    // Watchdog caused NMI
    output logic [NMI_CNT_W-1:0]      count,       // Live countdown
    output logic                      nmi_pulse,   // NMI request pulse
    output logic                      reset_pulse  // Countdown expired
);

    logic                 running;
    logic                 next_running;
    logic                 next_flag;
    logic [NMI_CNT_W-1:0] next_count;
    logic                 next_nmi;
    logic                 next_rst;

    // ========================================================
    // Next values; expiry set beats a software clear
    always_comb begin
        next_flag    = nmi_flag;
        next_running = running;
        next_count   = count;
        next_nmi     = 1'b0;
        next_rst     = 1'b0;
        if (wdt_expire) begin
            next_flag    = 1'b1;
            next_nmi     = 1'b1;
            next_running = 1'b1;
            next_count   = cnt_load;
        end else begin
            if (flag_clr) begin
                // Handler acknowledged: abandon the reset countdown
                next_flag    = 1'b0;
                next_running = 1'b0;
            end else if (running && tick) begin
                if (count == '0) begin
                    next_rst     = 1'b1;
                    next_running = 1'b0;
                end else begin
                    next_count = count - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            nmi_flag    <= 1'b0;
            running     <= 1'b0;
            count       <= NMI_CNT_RST;
            nmi_pulse   <= 1'b0;
            reset_pulse <= 1'b0;
        end else begin
            nmi_flag    <= next_flag;
            running     <= next_running;
            count       <= next_count;
            nmi_pulse   <= next_nmi;
            reset_pulse <= next_rst;
        end
    end

    // ========================================================
    // Checks
    AST_NMI_FLAG: assert property (@(posedge mclk) disable iff (srst)
        wdt_expire |=> nmi_flag && nmi_pulse && !reset_pulse)
        else $error("watchdog expiry did not raise NMI");
    AST_NMI_RESET: assert property (@(posedge mclk) disable iff (srst)
        (running && tick && count == '0 && !wdt_expire && !flag_clr)
        |=> reset_pulse ##1 !reset_pulse)
        else $error("NMI countdown expiry did not reset");

endmodule : spmc_nmi_cnt

`default_nettype wire

//--- verification/spmc_cpu_model.sv
// Behavioural CPU core and interrupt controller facing the sequencer.
// Assumes the bench calls its tasks; signals move only at mclk rises.
`default_nettype none

module spmc_cpu_model #(
    parameter int PRIO_W = 3  // Interrupt priority width
) (
    input  wire logic         mclk,         // Core clock
    output logic              halt_exec,    // Halt instr pulse
    output logic              irq_req,      // Interrupt pending
    output logic              irq_enabled,  // Source enabled
    output logic              irq_in_sleep, // Source runs in Sleep
    output logic [PRIO_W-1:0] irq_priority, // Pending priority
    output logic [PRIO_W-1:0] cpu_priority  // Current CPU priority
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Quiet at start; CPU sits at a mid priority so both sides test
    initial begin
        halt_exec = 1'b0;
        irq_req = 1'b0;
        irq_enabled = 1'b0;
        irq_in_sleep = 1'b0;
        irq_priority = '0;
        cpu_priority = 3'h3;
    end

    // One-cycle halt instruction, returns just after it is taken
    task automatic halt;
        @(posedge mclk);
        halt_exec <= 1'b1;
        @(posedge mclk);
        halt_exec <= 1'b0;
        #1;
    endtask : halt

    // One-cycle interrupt request with its qualifiers
    task automatic irq(input logic en, input logic slp, input logic [PRIO_W-1:0] pri);
        @(posedge mclk);
        irq_req <= 1'b1;
        irq_enabled <= en;
        irq_in_sleep <= slp;
        irq_priority <= pri;
        @(posedge mclk);
        irq_req <= 1'b0;
        #1;
    endtask : irq
endmodule : spmc_cpu_model

`default_nettype wire

//--- verification/tb_sleep_idle_power_mode_control.sv
// Self-checking bench for the power-mode sequencer.
// Assumes spmc_pkg is compiled first; the CPU side is a behavioural model.
`default_nettype none

`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) begin \
            miscompares++; \
            $display("BAD %s exp %h got %h", nm, ex, got); \
        end \
    end
`define WAITV(cond, n) \
    for (int k = 0; k < (n) && !(cond); k++) begin \
        cyc(1); \
    end
`define PULSE(s) \
    @(posedge mclk); \
    s <= 1'b1; \
    @(posedge mclk); \
    s <= 1'b0; \
    #1;

module tb_sleep_idle_power_mode_control
    import spmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Stimulus and observed signals
    logic mclk = 1'b0, srst = 1'b1, osc_needs_startup = 1'b0, device_reset_req = 1'b0;
    logic wdt_timeout = 1'b0, brownout_pin = 1'b0, nmi_flag_clr = 1'b0;
    logic [31:0] oscillator_control_reg = 32'h0, power_control_reg = 32'h0;
    logic [7:0]  halt_in_idle_sel = 8'h0f, nmi_cnt_load = 8'h02;
    logic halt_exec, irq_req, irq_enabled, irq_in_sleep, cpu_halt, cpu_clk_en, pb_clk_en;
    logic sleep_periph_en, watchdog_run, clock_fail_monitor_en, brownout_reset_detect_en;
    logic io_drive_keep, regulator_standby, nmi_out, device_reset_out;
    logic [2:0]  irq_priority, cpu_priority;
    logic [7:0]  periph_run;
    logic [3:0]  power_mode;
    logic [31:0] nmi_control_reg;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #2 mclk = ~mclk;

    spmc_cpu_model u_cpu (.mclk, .halt_exec, .irq_req, .irq_enabled, .irq_in_sleep,
        .irq_priority, .cpu_priority);

    spmc_seq u_dut (.mclk, .srst, .halt_exec, .oscillator_control_reg, .power_control_reg,
        .osc_needs_startup, .irq_req, .irq_enabled, .irq_in_sleep, .irq_priority,
        .cpu_priority, .device_reset_req, .wdt_timeout, .brownout_pin, .halt_in_idle_sel,
        .nmi_flag_clr, .nmi_cnt_load, .cpu_halt, .cpu_clk_en, .pb_clk_en, .periph_run,
        .sleep_periph_en, .watchdog_run, .clock_fail_monitor_en, .brownout_reset_detect_en,
        .io_drive_keep, .regulator_standby, .power_mode, .nmi_out, .device_reset_out,
        .nmi_control_reg);

    // ==========================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic final_report;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Enter Sleep and check everything that must hold there except cpu_halt
    task automatic go_sleep(input logic keep);
        @(posedge mclk);
        oscillator_control_reg <= 32'h10;
        power_control_reg <= {31'h0, keep};
        u_cpu.halt();
        `CHK("mode", SPMC_SLEEP, power_mode)
        `CHK("pb_clk", 1'b0, pb_clk_en)
        `CHK("cpu_clk", 1'b0, cpu_clk_en)
        `CHK("periph", 8'h00, periph_run)
        `CHK("cfm", 1'b0, clock_fail_monitor_en)
        `CHK("bor", 1'b1, brownout_reset_detect_en)
        `CHK("wdt_run", 1'b1, watchdog_run)
        `CHK("slp_per", 1'b1, sleep_periph_en)
        `CHK("io", 1'b1, io_drive_keep)
        `CHK("reg_stby", ~keep, regulator_standby)
    endtask : go_sleep

    // ==========================================================
    // Scenarios
    task automatic t_idle;
        @(posedge mclk);
        oscillator_control_reg <= 32'h0;
        u_cpu.halt();
        `CHK("mode", SPMC_IDLE, power_mode)
        `CHK("cpu_halt", 1'b1, cpu_halt)
        `CHK("pb_clk", 1'b1, pb_clk_en)
        `CHK("periph", 8'hf0, periph_run)
        u_cpu.irq(1'b1, 1'b0, 3'h3);
        cyc(3);
        `CHK("mode", SPMC_IDLE, power_mode)
        u_cpu.irq(1'b1, 1'b0, 3'h4);
        `CHK("mode", SPMC_RUN, power_mode)
    endtask : t_idle

    // Low priority drops Sleep to Idle; a source not running in Sleep is ignored
    task automatic t_sleep_idle;
        go_sleep(1'b0);
        u_cpu.irq(1'b1, 1'b0, 3'h7);
        cyc(2);
        `CHK("mode", SPMC_SLEEP, power_mode)
        u_cpu.irq(1'b1, 1'b1, 3'h2);
        `CHK("mode", SPMC_IDLE, power_mode)
        `CHK("pb_clk", 1'b1, pb_clk_en)
        `CHK("cpu_halt", 1'b1, cpu_halt)
        u_cpu.irq(1'b1, 1'b0, 3'h5);
    endtask : t_sleep_idle

    // Slow oscillator stretches the wake; then a reset ends Sleep
    task automatic t_sleep_wake;
        @(posedge mclk);
        osc_needs_startup <= 1'b1;
        go_sleep(1'b1);
        u_cpu.irq(1'b1, 1'b1, 3'h5);
        `CHK("mode", SPMC_WAKE, power_mode)
        cyc(200);
        `CHK("mode", SPMC_WAKE, power_mode)
        `WAITV(power_mode === SPMC_RUN, 100)
        `CHK("mode", SPMC_RUN, power_mode)
        @(posedge mclk);
        osc_needs_startup <= 1'b0;
        go_sleep(1'b1);
        `PULSE(device_reset_req)
        `WAITV(power_mode === SPMC_RUN, 6)
        `CHK("mode", SPMC_RUN, power_mode)
        `CHK("cfm", 1'b1, clock_fail_monitor_en)
    endtask : t_sleep_wake

    // Watchdog in Idle: wake, NMI, countdown to reset; then brown-out
    task automatic t_wdt;
        @(posedge mclk);
        oscillator_control_reg <= 32'h0;
        u_cpu.halt();
        `PULSE(wdt_timeout)
        `WAITV(power_mode === SPMC_RUN, 3)
        `CHK("mode", SPMC_RUN, power_mode)
        `WAITV(nmi_out === 1'b1, 4)
        `CHK("nmi", 1'b1, nmi_out)
        `CHK("wdt_flag", 1'b1, nmi_control_reg[24])
        `CHK("nmi_cnt", 8'h02, nmi_control_reg[7:0])
        `WAITV(device_reset_out === 1'b1, 60)
        `CHK("rst_out", 1'b1, device_reset_out)
        // Flag outlives the countdown reset until software clears it
        `CHK("wdt_flag", 1'b1, nmi_control_reg[24])
        `PULSE(nmi_flag_clr)
        cyc(1);
        `CHK("wdt_flag", 1'b0, nmi_control_reg[24])
        `PULSE(brownout_pin)
        `WAITV(device_reset_out === 1'b1, 8)
        `CHK("bor_rst", 1'b1, device_reset_out)
    endtask : t_wdt

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        cyc(1);
        t_idle();
        t_sleep_idle();
        t_sleep_wake();
        t_wdt();
        final_report();
    end

    initial begin
        #20000;
        miscompares++;
        final_report();
    end
endmodule : tb_sleep_idle_power_mode_control

`default_nettype wire
